/* File: dv/plg_bench.sv */
// Self-checking bench for the pulse generator
`timescale 1ns/1ns
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected at %0t: line %0d got %0h expected %0h", $time, `__LINE__, (got), (exp)); end end
module plg_bench import plg_pkg::*; ();
  typedef struct {logic [2:0] ctrl; logic [4:0] dly; logic [8:0] wid; int dl; int wd;} plg_row_t;
  plg_row_t rows[6] = '{'{3'h2, 5'h00, 9'h001, 0, 1}, '{3'h2, 5'h00, 9'h000, 0, 1}, '{3'h2, 5'h03, 9'h00A, 3, 10},
    '{3'h2, 5'h1F, 9'h1FF, 31, 511}, '{3'h0, 5'h00, 9'h005, 0, 0}, '{3'h6, 5'h00, 9'h005, 0, 0}};
  logic [2:0] pat[4] = '{3'h3, 3'h5, 3'h6, 3'h6};
  int lo_e[4] = '{3, 3, 10, 60};
  int hi_e[4] = '{5, 5, 13, 60};
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, trig_want;
  logic awready, wready, bvalid, arready, rvalid, pulse_out_n, trig_c, stop_a, stop_b, stop_c;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, strb, lag, ref_b;
  logic [4:0] ref_a;
  logic [2:0] stop_want;
  logic [1:0] bresp, rresp, rsp;
  int n_errors = 0, checked = 0, cyc = 0, lo = 0, last_wd = 0, t_fall = 0, n_done = 0;

  plg_top #(.ADDR_W(8)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trigger_comparator(trig_c),
    .stop_comparator_a(stop_a), .stop_comparator_b(stop_b), .stop_comparator_c(stop_c),
    .pulse_out_n(pulse_out_n), .stop_ref_a_select(ref_a), .stop_ref_b_select(ref_b));
  plg_cmp_model cmp (.aclk(aclk), .trig_want(trig_want), .stop_want(stop_want), .lag(lag),
    .trigger_comparator(trig_c), .stop_comparator_a(stop_a), .stop_comparator_b(stop_b),
    .stop_comparator_c(stop_c));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Low-run tracker; a hang past the ceiling ends the run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (pulse_out_n === 1'b0) begin
      lo <= lo + 1;
      if (lo == 0) t_fall <= cyc;
    end else if (lo != 0) begin
      last_wd <= lo;
      n_done <= n_done + 1;
      lo <= 0;
    end
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      k++;
    end while (bvalid !== 1'b1 && k < 50);
    `CHK(bvalid, 1'b1)
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      k++;
    end while (rvalid !== 1'b1 && k < 50);
    `CHK(rvalid, 1'b1)
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic fire(input logic [2:0] c);
    wr(CTRL_OFS, {29'h0, c | 3'h1}, rsp);
    wr(CTRL_OFS, {29'h0, c}, rsp);
  endtask

  // Width 0 means no pulse wanted, a negative figure skips that comparison
  task automatic chk_p(input int c0, input int dl, input int wd, input int lim, output int ofs);
    int k, nd;
    k = 0;
    nd = n_done;
    while (n_done == nd && k < lim) begin
      @(posedge aclk);
      k++;
    end
    ofs = t_fall - c0;
    if (wd == 0) begin
      `CHK({n_done, lo}, {nd, 32'h0000_0000})
    end else begin
      `CHK(n_done, nd + 1)
      if (wd > 0) `CHK(last_wd, wd)
      if (dl >= 0) `CHK(ofs, dl)
    end
  endtask

  task automatic trg(input logic [5:0] n, input logic [4:0] dly, input logic sel, output int lat);
    int g;
    wr(TRIG_OFS, {25'h0, sel, n}, rsp);
    wr(DLY_OFS, {21'h0, 3'h3, 3'h0, dly}, rsp);
    wr(CTRL_OFS, 32'h0000_0006, rsp);
    @(posedge aclk);
    trig_want <= sel;
    chk_p(cyc, -1, 4, 80, lat);
    @(posedge aclk);
    trig_want <= ~sel;
    chk_p(cyc, -1, 0, 20 + n, g);
  endtask

  initial begin
    logic [31:0] d;
    int c0, g, lat0, lat1;
    aresetn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    strb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    trig_want = 1'b1;
    stop_want = 3'h7;
    lag = 4'h0;
    repeat (12) @(posedge aclk);
    `CHK(pulse_out_n, 1'b1)
    aresetn <= 1'b1;
    rd(CTRL_OFS, d, rsp);
    `CHK(d, 32'h0000_0000)
    wr(REF_OFS, 32'h0000_0A15, rsp);
    @(posedge aclk);
    `CHK({ref_b, ref_a}, 9'h155)
    strb = 4'h1;
    wr(REF_OFS, 32'h0000_0F07, rsp);
    strb = 4'hF;
    rd(REF_OFS, d, rsp);
    `CHK(d, 32'h0000_0A07)
    wr(8'h20, 32'h0000_0001, rsp);
    `CHK(rsp, RESP_SLVERR)
    rd(8'h20, d, rsp);
    `CHK({rsp, d}, {RESP_SLVERR, 32'h0000_0000})
    foreach (rows[i]) begin
      wr(DLY_OFS, {21'h0, 3'h3, 3'h0, rows[i].dly}, rsp);
      wr(WIDTH_OFS, {23'h0, rows[i].wid}, rsp);
      fire(rows[i].ctrl);
      chk_p(cyc, rows[i].dl, rows[i].wd, 600, g);
    end
    // New width mid-pulse must wait for the next pulse
    wr(WIDTH_OFS, 32'h0000_0028, rsp);
    fire(3'h2);
    c0 = cyc;
    wr(WIDTH_OFS, 32'h0000_0005, rsp);
    chk_p(c0, 0, 40, 100, g);
    fire(3'h2);
    chk_p(cyc, 0, 5, 100, g);
    wr(WIDTH_OFS, 32'h0000_0004, rsp);
    trg(6'h00, 5'h00, 1'b0, lat0);
    `CHK(lat0 >= 7 && lat0 <= 12, 1'b1)
    trg(6'h00, 5'h03, 1'b0, lat1);
    `CHK(lat1 - lat0, 3)
    trg(6'h05, 5'h00, 1'b0, lat1);
    `CHK(lat1 - lat0, 5)
    @(posedge aclk);
    trig_want <= 1'b0;
    repeat (5) @(posedge aclk);
    trig_want <= 1'b1;
    chk_p(cyc, -1, 0, 40, g);
    wr(CTRL_OFS, 32'h0000_0002, rsp);
    @(posedge aclk);
    trig_want <= 1'b0;
    chk_p(cyc, -1, 0, 20, g);
    lag <= 4'h2;
    trg(6'h00, 5'h00, 1'b1, lat1);
    `CHK(lat1, lat0 + 2)
    lag <= 4'h0;
    // Stops a, b, c, then a c dip one clock short of qualifying
    for (int k = 0; k < 4; k++) begin
      @(posedge aclk);
      trig_want <= 1'b0;
      stop_want <= 3'h7;
      chk_p(cyc, -1, 0, 10, g);
      wr(WIDTH_OFS, 32'h0000_003C, rsp);
      wr(CTRL_OFS, 32'h0000_0006, rsp);
      @(posedge aclk);
      trig_want <= 1'b1;
      g = 0;
      while (pulse_out_n !== 1'b0 && g < 40) begin
        @(posedge aclk);
        g++;
      end
      stop_want <= pat[k];
      if (k == 3) begin
        repeat (7) @(posedge aclk);
        stop_want <= 3'h7;
      end
      chk_p(cyc, -1, -1, 100, g);
      `CHK(last_wd >= lo_e[k] && last_wd <= hi_e[k], 1'b1)
      rd(CTRL_OFS, d, rsp);
      `CHK(d, (k == 3) ? 32'h0000_0006 : 32'h0000_0002)
      if (k < 3) begin
        @(posedge aclk);
        stop_want <= 3'h7;
        trig_want <= 1'b0;
        chk_p(cyc, -1, 0, 10, g);
        trig_want <= 1'b1;
        chk_p(cyc, -1, 0, 30, g);
      end
    end
    rd(STAT_OFS, d, rsp);
    `CHK(d[STAT_STOP_BIT], 1'b1)
    wr(STAT_OFS, 32'h0000_0008, rsp);
    rd(STAT_OFS, d, rsp);
    `CHK(d[STAT_STOP_BIT], 1'b0)
    // Reset in mid-pulse must cut the pulse and drop the settings
    fire(3'h2);
    `CHK(pulse_out_n, 1'b0)
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK(pulse_out_n, 1'b1)
    aresetn <= 1'b1;
    rd(WIDTH_OFS, d, rsp);
    `CHK(d, 32'h0000_0000)
    test_done();
  end
endmodule

/* File: dv/plg_cmp_model.sv */
// Comparator outputs feeding the pulse generator, with a selectable lag
`timescale 1ns/1ns
module plg_cmp_model (
  input wire logic aclk,
  input wire logic trig_want,
  input wire logic [2:0] stop_want,
  input wire logic [3:0] lag,
  output logic trigger_comparator,
  output logic stop_comparator_a,
  output logic stop_comparator_b,
  output logic stop_comparator_c
);
  logic [15:0][3:0] pipe_r;
  // Slow comparators settle some clocks after the inputs cross
  always_ff @(posedge aclk) begin
    pipe_r <= {pipe_r[14:0], trig_want, stop_want};
  end
  assign {trigger_comparator, stop_comparator_a, stop_comparator_b, stop_comparator_c} = pipe_r[lag];
endmodule

/* File: logic/plg_pkg.sv */
// Constants and types for the programmable pulse generator
package plg_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] WIDTH_OFS = 8'h04;
  localparam logic [7:0] TRIG_OFS = 8'h08;
  localparam logic [7:0] DLY_OFS = 8'h0C;
  localparam logic [7:0] REF_OFS = 8'h10;
  localparam logic [7:0] STAT_OFS = 8'h14;
  localparam int CTRL_STB_BIT = 0;
  localparam int CTRL_GEN_BIT = 1;
  localparam int CTRL_TEN_BIT = 2;
  localparam int TRIG_DBN_LSB = 0;
  localparam int TRIG_EDGE_BIT = 6;
  localparam int DLY_LSB = 0;
  localparam int QUAL_LSB = 8;
  localparam int REFA_LSB = 0;
  localparam int REFB_LSB = 8;
  localparam int STAT_ACT_BIT = 0;
  localparam int STAT_WAIT_BIT = 1;
  localparam int STAT_DEB_BIT = 2;
  localparam int STAT_STOP_BIT = 3;
  localparam logic [5:0] TRIG_LAT = 6'h06;
  localparam logic [7:0] QUAL_UNIT = 8'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic trig_en;
    logic gen_en;
    logic strobe;
    logic [8:0] width;
    logic edge_sel;
    logic [5:0] dbnc;
    logic [4:0] dly;
    logic [2:0] qual;
    logic [4:0] ref_a;
    logic [3:0] ref_b;
  } plg_cfg_t;
  localparam plg_cfg_t CFG_RST = '0;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACTIVE} plg_state_t;
endpackage

/* File: logic/plg_top.sv */
// Programmable low pulse generator with AXI4-Lite registers
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module plg_top import plg_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trigger_comparator,
  input wire logic stop_comparator_a,
  input wire logic stop_comparator_b,
  input wire logic stop_comparator_c,
  output logic pulse_out_n,
  output logic [4:0] stop_ref_a_select,
  output logic [3:0] stop_ref_b_select
);
  plg_cfg_t cfg_r, cfg_nxt;
  logic stop_seen_r, stop_seen_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic aw_full_r, aw_full_nxt, awready_r, awready_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic w_full_r, w_full_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_do, strobe_fall;
  logic [31:0] ctrl_w, width_w, trig_w, dly_w, ref_w, stat_w, cur_w, new_w, mask;
  logic [7:0] wr_ofs, rd_ofs;

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign stop_ref_a_select = cfg_r.ref_a;
  assign stop_ref_b_select = cfg_r.ref_b;

  // Trigger debounce, edge detect and stop qualification
  logic trig_deb_r, trig_deb_nxt, trig_prev_r;
  logic [5:0] dbn_cnt_r, dbn_cnt_nxt;
  logic stop_a_prev_r, stop_b_prev_r;
  logic c_qual_r, c_qual_nxt;
  logic [7:0] c_low_cnt_r, c_low_cnt_nxt, qual_len;
  logic edge_evt, stop_evt;

  always_comb begin
    trig_deb_nxt = trig_deb_r;
    dbn_cnt_nxt = '0;
    if (trigger_comparator != trig_deb_r) begin
      if (dbn_cnt_r >= cfg_r.dbnc) begin
        trig_deb_nxt = trigger_comparator;
      end else begin
        dbn_cnt_nxt = dbn_cnt_r + 6'h01;
      end
    end
    // Shift range 0..7 keeps qualify length within 8 bits
    qual_len = QUAL_UNIT << cfg_r.qual;
    c_low_cnt_nxt = '0;
    c_qual_nxt = 1'b1;
    if (!stop_comparator_c) begin
      c_low_cnt_nxt = (c_low_cnt_r == 8'hFF) ? c_low_cnt_r : c_low_cnt_r + 8'h01;
      c_qual_nxt = c_qual_r && ((c_low_cnt_r + 8'h01) < qual_len);
    end
    edge_evt = cfg_r.edge_sel ? (trig_deb_r && !trig_prev_r) : (!trig_deb_r && trig_prev_r);
    stop_evt = (stop_a_prev_r && !stop_comparator_a) || (stop_b_prev_r && !stop_comparator_b) ||
               (c_qual_r && !c_qual_nxt);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_deb_r <= 1'b1;
      trig_prev_r <= 1'b1;
      dbn_cnt_r <= '0;
      stop_a_prev_r <= 1'b0;
      stop_b_prev_r <= 1'b0;
      c_qual_r <= 1'b1;
      c_low_cnt_r <= '0;
    end else begin
      trig_deb_r <= trig_deb_nxt;
      trig_prev_r <= trig_deb_r;
      dbn_cnt_r <= dbn_cnt_nxt;
      stop_a_prev_r <= stop_comparator_a;
      stop_b_prev_r <= stop_comparator_b;
      c_qual_r <= c_qual_nxt;
      c_low_cnt_r <= c_low_cnt_nxt;
    end
  end

  // Pulse sequencer
  plg_state_t state_r, state_nxt;
  logic [5:0] wait_r, wait_nxt, total;
  logic [8:0] cnt_r, cnt_nxt, wlat_r, wlat_nxt;
  logic pulse_n_r, pulse_n_nxt;
  logic start_single, start_cont;

  always_comb begin
    start_single = strobe_fall && cfg_r.gen_en && !cfg_r.trig_en;
    start_cont = edge_evt && cfg_r.gen_en && cfg_r.trig_en;
    total = (start_cont ? TRIG_LAT : 6'h00) + {1'b0, cfg_r.dly};
    state_nxt = state_r;
    wait_nxt = wait_r;
    cnt_nxt = cnt_r;
    wlat_nxt = wlat_r;
    pulse_n_nxt = pulse_n_r;
    if (stop_evt) begin
      state_nxt = ST_IDLE;
      pulse_n_nxt = 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start_single || start_cont) begin
            wlat_nxt = cfg_r.width;
            cnt_nxt = 9'h001;
            if (total == 6'h00) begin
              state_nxt = ST_ACTIVE;
              pulse_n_nxt = 1'b0;
            end else begin
              state_nxt = ST_WAIT;
              wait_nxt = total - 6'h01;
            end
          end
        end
        ST_WAIT: begin
          if (wait_r == 6'h00) begin
            state_nxt = ST_ACTIVE;
            pulse_n_nxt = 1'b0;
          end else begin
            wait_nxt = wait_r - 6'h01;
          end
        end
        ST_ACTIVE: begin
          if (cnt_r >= wlat_r) begin
            state_nxt = ST_IDLE;
            pulse_n_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 9'h001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      wait_r <= '0;
      cnt_r <= '0;
      wlat_r <= '0;
      pulse_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      wait_r <= wait_nxt;
      cnt_r <= cnt_nxt;
      wlat_r <= wlat_nxt;
      pulse_n_r <= pulse_n_nxt;
    end
  end
  assign pulse_out_n = pulse_n_r;

  // Register words and AXI4-Lite slave
  always_comb begin
    ctrl_w = '0;
    ctrl_w[CTRL_STB_BIT] = cfg_r.strobe;
    ctrl_w[CTRL_GEN_BIT] = cfg_r.gen_en;
    ctrl_w[CTRL_TEN_BIT] = cfg_r.trig_en;
    width_w = {23'h00_0000, cfg_r.width};
    trig_w = '0;
    trig_w[TRIG_DBN_LSB +: 6] = cfg_r.dbnc;
    trig_w[TRIG_EDGE_BIT] = cfg_r.edge_sel;
    dly_w = '0;
    dly_w[DLY_LSB +: 5] = cfg_r.dly;
    dly_w[QUAL_LSB +: 3] = cfg_r.qual;
    ref_w = '0;
    ref_w[REFA_LSB +: 5] = cfg_r.ref_a;
    ref_w[REFB_LSB +: 4] = cfg_r.ref_b;
    stat_w = '0;
    stat_w[STAT_ACT_BIT] = !pulse_n_r;
    stat_w[STAT_WAIT_BIT] = (state_r == ST_WAIT);
    stat_w[STAT_DEB_BIT] = trig_deb_r;
    stat_w[STAT_STOP_BIT] = stop_seen_r;
    wr_ofs = 8'(aw_addr_r) & 8'hFC;
    rd_ofs = 8'(s_axi_araddr) & 8'hFC;
    mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    unique case (wr_ofs)
      CTRL_OFS: cur_w = ctrl_w;
      WIDTH_OFS: cur_w = width_w;
      TRIG_OFS: cur_w = trig_w;
      DLY_OFS: cur_w = dly_w;
      REF_OFS: cur_w = ref_w;
      default: cur_w = '0;
    endcase
    new_w = (cur_w & ~mask) | (w_data_r & mask);
  end

  always_comb begin
    wr_do = aw_full_r && w_full_r && !bvalid_r;
    strobe_fall = 1'b0;
    cfg_nxt = cfg_r;
    stop_seen_nxt = stop_seen_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid && awready_r) begin
      aw_addr_nxt = s_axi_awaddr;
      aw_full_nxt = 1'b1;
    end
    if (s_axi_wvalid && wready_r) begin
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
      w_full_nxt = 1'b1;
    end
    if (wr_do) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      unique case (wr_ofs)
        CTRL_OFS: begin
          cfg_nxt.strobe = new_w[CTRL_STB_BIT];
          cfg_nxt.gen_en = new_w[CTRL_GEN_BIT];
          cfg_nxt.trig_en = new_w[CTRL_TEN_BIT];
          strobe_fall = cfg_r.strobe && !new_w[CTRL_STB_BIT];
        end
        WIDTH_OFS: cfg_nxt.width = new_w[8:0];
        TRIG_OFS: begin
          cfg_nxt.dbnc = new_w[TRIG_DBN_LSB +: 6];
          cfg_nxt.edge_sel = new_w[TRIG_EDGE_BIT];
        end
        DLY_OFS: begin
          cfg_nxt.dly = new_w[DLY_LSB +: 5];
          cfg_nxt.qual = new_w[QUAL_LSB +: 3];
        end
        REF_OFS: begin
          cfg_nxt.ref_a = new_w[REFA_LSB +: 5];
          cfg_nxt.ref_b = new_w[REFB_LSB +: 4];
        end
        STAT_OFS: begin
          if (new_w[STAT_STOP_BIT] && mask[STAT_STOP_BIT]) begin
            stop_seen_nxt = 1'b0;
          end
        end
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    // Hardware stop overrides a same-cycle enable write
    if (stop_evt) begin
      cfg_nxt.trig_en = 1'b0;
      stop_seen_nxt = 1'b1;
    end
    awready_nxt = !aw_full_nxt;
    wready_nxt = !w_full_nxt;
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      unique case (rd_ofs)
        CTRL_OFS: rdata_nxt = ctrl_w;
        WIDTH_OFS: rdata_nxt = width_w;
        TRIG_OFS: rdata_nxt = trig_w;
        DLY_OFS: rdata_nxt = dly_w;
        REF_OFS: rdata_nxt = ref_w;
        STAT_OFS: rdata_nxt = stat_w;
        default: begin
          rdata_nxt = '0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= CFG_RST;
      stop_seen_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      cfg_r <= cfg_nxt;
      stop_seen_r <= stop_seen_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_single_start;
    start_single && state_r == ST_IDLE && cfg_r.dly == 5'h00 && !stop_evt |=> !pulse_out_n;
  endproperty
  a_single_start: assert property (p_single_start) else $error("single pulse did not start");

  property p_idle_high;
    state_r == ST_IDLE |-> pulse_out_n;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("output low while idle");

  property p_width_hold;
    state_r == ST_ACTIVE && $past(state_r) == ST_ACTIVE |-> $stable(wlat_r);
  endproperty
  a_width_hold: assert property (p_width_hold) else $error("width changed mid pulse");

  property p_cont_latency;
    start_cont && state_r == ST_IDLE && cfg_r.dly == 5'h00 && !stop_evt ##1 (!stop_evt)[*6]
      |-> pulse_out_n ##1 !pulse_out_n;
  endproperty
  a_cont_latency: assert property (p_cont_latency) else $error("trigger latency not 6");

  property p_stop;
    stop_evt |=> pulse_out_n && !cfg_r.trig_en && state_r == ST_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not end pulse");

  property p_width_end;
    state_r == ST_ACTIVE && cnt_r >= wlat_r && !stop_evt |=> pulse_out_n;
  endproperty
  a_width_end: assert property (p_width_end) else $error("pulse not ended at width");

  property p_debounce;
    $changed(trig_deb_r) |-> $past(dbn_cnt_r) >= $past(cfg_r.dbnc);
  endproperty
  a_debounce: assert property (p_debounce) else $error("debounce too short");

  property p_qual8;
    cfg_r.qual == 3'h3 && c_qual_r && !c_qual_nxt |-> c_low_cnt_r == 8'h07;
  endproperty
  a_qual8: assert property (p_qual8) else $error("third stop not qualified by 8");
endmodule
